// *** rtl/drive_params.svh ***
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH

// clock and display timing
`define CLK_PERIOD_NS 50
`define SEQ_PERIOD_MS 1000
`define SEQ_CYCLES_DEF (`SEQ_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define SEQ_SLOTS 4
`define TICK_W 25

// display modes
`define MODE_NORMAL 1'b0
`define MODE_COMMISSION 1'b1

// fault numbers and which of them an acknowledge may clear
`define FAULT_N 5
`define F_HW 0
`define F_SUPPLY 1
`define F_PHASE 2
`define F_CABLE 3
`define F_DCLINK 4
`define FAULT_NONE 5'h00
`define ACKABLE_MASK 5'h1c
`define FAULT_TENS 4'h0

// dc link limit in volts
`define DC_LINK_MAX_V 10'h1e0

// state codes shown on the display
`define CODE_INIT 4'h0
`define CODE_INHIBIT 4'h1
`define CODE_ARMABLE 4'h2
`define CODE_ON 4'h3
`define CODE_ENABLED 4'h4
`define CODE_QSTOP 4'h7
`define CODE_REACT 4'he
`define CODE_LOCKED 4'hf

// display sequence slots
`define SLOT_LETTER 2'h0
`define SLOT_TENS 2'h1
`define SLOT_UNITS 2'h2

`endif

// *** rtl/drive_pkg.sv ***
`include "drive_params.svh"
package drive_pkg;

  typedef enum logic [2:0] {
    ST_INIT     = 3'h0,
    ST_INHIBIT  = 3'h1,
    ST_ARMABLE  = 3'h3,
    ST_ON       = 3'h2,
    ST_ENABLED  = 3'h6,
    ST_QSTOP    = 3'h7,
    ST_REACT    = 3'h5,
    ST_LOCKED   = 3'h4
  } drive_st_t;

  typedef enum logic [4:0] {
    G_0 = 5'h00, G_1 = 5'h01, G_2 = 5'h02, G_3 = 5'h03, G_4 = 5'h04,
    G_5 = 5'h05, G_6 = 5'h06, G_7 = 5'h07, G_8 = 5'h08, G_9 = 5'h09,
    G_C = 5'h0c, G_E = 5'h0e, G_F = 5'h0f, G_L = 5'h10, G_P = 5'h11,
    G_U = 5'h12, G_BLANK = 5'h1f
  } glyph_t;

  typedef enum logic [2:0] {
    BOOT_SECTOR = 3'h0,
    BOOT_CLEAR_C = 3'h1,
    BOOT_CLEAR_E = 3'h2,
    BOOT_LOADER = 3'h3,
    BOOT_PROGRAM = 3'h4,
    BOOT_AWAIT = 3'h5
  } boot_t;

  typedef struct packed {
    drive_st_t st;
    logic [`FAULT_N-1:0] fault_pend;
    logic fault_any;
    logic cable_tested;
    logic [`TICK_W-1:0] tick;
    logic [1:0] slot;
    logic flash;
    logic motor_pwr;
    logic dc_mon;
    logic [3:0] code;
    glyph_t glyph;
    logic dp;
  } ctl_t;

  typedef struct packed {
    logic [6:0] seg;
    logic dp;
  } enc_t;

endpackage

// *** rtl/seg_if.sv ***
`timescale 1ns/1ps
interface seg_if;
  import drive_pkg::*;
  glyph_t glyph;
  logic dp;
  logic [6:0] seg;
  logic seg_dp;
  modport src (output glyph, output dp, input seg, input seg_dp);
  modport enc (input glyph, input dp, output seg, output seg_dp);
endinterface

// *** rtl/seg_encoder.sv ***
`timescale 1ns/1ps
`include "drive_params.svh"
module seg_encoder import drive_pkg::*; (
  input wire logic clk_sys,
  input wire logic resetn,
  seg_if.enc sif
);

  enc_t r;
  enc_t n;

  // segments gfedcba, active high
  function automatic logic [6:0] segs(input glyph_t g);
    case (g)
      G_0: segs = 7'h3f;
      G_1: segs = 7'h06;
      G_2: segs = 7'h5b;
      G_3: segs = 7'h4f;
      G_4: segs = 7'h66;
      G_5: segs = 7'h6d;
      G_6: segs = 7'h7d;
      G_7: segs = 7'h07;
      G_8: segs = 7'h7f;
      G_9: segs = 7'h6f;
      G_C: segs = 7'h39;
      G_E: segs = 7'h79;
      G_F: segs = 7'h71;
      G_L: segs = 7'h38;
      G_P: segs = 7'h73;
      G_U: segs = 7'h3e;
      default: segs = 7'h00;
    endcase
  endfunction

  always_comb begin
    n.seg = segs(sif.glyph);
    n.dp = sif.dp;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sif.seg = r.seg;
  assign sif.seg_dp = r.dp;

endmodule // seg_encoder

// *** rtl/drive_state_fault_display.sv ***
`timescale 1ns/1ps
`include "drive_params.svh"
// How it works
// - display mode 0 normal (reset default), mode 1 commissioning
// - initialising after power-up: not-ready state, code 0
// - after init or acknowledge: switch-on inhibit, code 1, arming allowed
// - software disable gives ready-to-switch-on, code 2
// - switched on: dc link monitoring active, code 3
// - controller enabled: operation enabled, code 4
// - quick stop: code 7, decelerate to zero speed, then switch-on inhibit
// - error recognised: code E while error reaction runs
// - reaction over: state_fault_locked, locked, code F, acknowledge accepted
// - pending fault: F, then two digits, repeated every second
// - boot and update: flashing 0. C. E. L. P. U. codes
// - hardware defect or supply fault: power off, report 00 or 01
// - phase loss is fault 02 only in 3-phase setup, ackable
// - cable tested at first enable, break is fault 03, ackable
// - dc link above 480 V is fault 04, power off, ackable
module drive_state_fault_display import drive_pkg::*; #(
  parameter int SEQ_CYCLES = `SEQ_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic display_mode,
  input wire logic init_done,
  input wire logic cmd_arm,
  input wire logic cmd_switch_on,
  input wire logic cmd_enable,
  input wire logic cmd_disable,
  input wire logic cmd_quick_stop,
  input wire logic speed_zero,
  input wire logic err_reaction_done,
  input wire logic fault_ack,
  input wire logic three_phase_cfg,
  input wire logic hw_defect,
  input wire logic supply_bad,
  input wire logic phase_lost,
  input wire logic cable_broken,
  input wire logic [9:0] dc_link_volts,
  input wire logic boot_active,
  input wire logic [2:0] boot_phase,
  input wire logic warning,
  output logic [6:0] seg,
  output logic seg_dp,
  output logic [3:0] state_code,
  output logic motor_power_en,
  output logic dc_monitor_on,
  output logic fault_active
);

  localparam logic [`TICK_W-1:0] SLOT_CYCLES =
    `TICK_W'(SEQ_CYCLES / `SEQ_SLOTS);

  ctl_t r;
  ctl_t n;
  logic [`FAULT_N-1:0] det;
  logic [`FAULT_N-1:0] ack_clr;
  logic first_enable;
  logic [3:0] unit;
  seg_if sif ();

  function automatic glyph_t digit(input logic [3:0] v);
    digit = glyph_t'({1'b0, v});
  endfunction

  function automatic logic [3:0] code_of(input drive_st_t s);
    case (s)
      ST_INIT: code_of = `CODE_INIT;
      ST_INHIBIT: code_of = `CODE_INHIBIT;
      ST_ARMABLE: code_of = `CODE_ARMABLE;
      ST_ON: code_of = `CODE_ON;
      ST_ENABLED: code_of = `CODE_ENABLED;
      ST_QSTOP: code_of = `CODE_QSTOP;
      ST_REACT: code_of = `CODE_REACT;
      default: code_of = `CODE_LOCKED;
    endcase
  endfunction

  function automatic logic [3:0] lowest(input logic [`FAULT_N-1:0] p);
    lowest = 4'h0;
    for (int i = `FAULT_N - 1; i >= 0; i--) begin
      if (p[i]) begin
        lowest = 4'(i);
      end
    end
  endfunction

  function automatic glyph_t boot_glyph(input logic [2:0] b);
    case (boot_t'(b))
      BOOT_SECTOR: boot_glyph = G_0;
      BOOT_CLEAR_C: boot_glyph = G_C;
      BOOT_CLEAR_E: boot_glyph = G_E;
      BOOT_LOADER: boot_glyph = G_L;
      BOOT_PROGRAM: boot_glyph = G_P;
      BOOT_AWAIT: boot_glyph = G_U;
      default: boot_glyph = G_BLANK;
    endcase
  endfunction

  always_comb begin
    n = r;
    first_enable = (r.st == ST_ON) && cmd_enable && !r.cable_tested;
    det = `FAULT_NONE;
    det[`F_HW] = hw_defect;
    det[`F_SUPPLY] = supply_bad;
    det[`F_PHASE] = phase_lost && three_phase_cfg;
    det[`F_CABLE] = first_enable && cable_broken;
    det[`F_DCLINK] = dc_link_volts > `DC_LINK_MAX_V;
    n.cable_tested = r.cable_tested || ((r.st == ST_ON) && cmd_enable);
    ack_clr = (fault_ack && r.st == ST_LOCKED) ? `ACKABLE_MASK : `FAULT_NONE;
    // a new detection wins over an acknowledge in the same cycle
    n.fault_pend = (r.fault_pend & ~ack_clr) | det;
    n.fault_any = |n.fault_pend;
    case (r.st)
      ST_INIT: begin
        if (init_done) begin
          n.st = ST_INHIBIT;
        end
      end
      ST_INHIBIT: begin
        if (cmd_arm) begin
          n.st = ST_ARMABLE;
        end
      end
      ST_ARMABLE: begin
        if (cmd_switch_on) begin
          n.st = ST_ON;
        end
      end
      ST_ON: begin
        if (cmd_disable) begin
          n.st = ST_ARMABLE;
        end else if (cmd_enable) begin
          n.st = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (cmd_disable) begin
          n.st = ST_ARMABLE;
        end else if (cmd_quick_stop) begin
          n.st = ST_QSTOP;
        end
      end
      ST_QSTOP: begin
        if (speed_zero) begin
          n.st = ST_INHIBIT;
        end
      end
      ST_REACT: begin
        if (err_reaction_done) begin
          n.st = ST_LOCKED;
        end
      end
      default: begin
        if (fault_ack && (n.fault_pend == `FAULT_NONE)) begin
          n.st = ST_INHIBIT;
        end
      end
    endcase
    if (det != `FAULT_NONE && r.st != ST_LOCKED) begin
      n.st = ST_REACT;
    end
    // power drops in the cycle after any detection
    n.motor_pwr = (n.st == ST_ENABLED || n.st == ST_QSTOP) &&
                  (det == `FAULT_NONE);
    n.dc_mon = (n.st == ST_ON) || (n.st == ST_ENABLED) ||
               (n.st == ST_QSTOP);
    n.code = code_of(n.st);
    if (r.tick >= SLOT_CYCLES - `TICK_W'(1)) begin
      n.tick = '0;
      n.slot = r.slot + 2'h1;
      n.flash = !r.flash;
    end else begin
      n.tick = r.tick + `TICK_W'(1);
    end
    unit = lowest(r.fault_pend);
    n.dp = 1'b0;
    n.glyph = digit(r.code);
    if (display_mode == `MODE_COMMISSION) begin
      n.dp = r.motor_pwr;
    end else if (boot_active) begin
      n.glyph = r.flash ? boot_glyph(boot_phase) : G_BLANK;
      n.dp = r.flash;
    end else if (r.fault_pend != `FAULT_NONE) begin
      case (r.slot)
        `SLOT_LETTER: n.glyph = G_F;
        `SLOT_TENS: begin
          n.glyph = digit(`FAULT_TENS);
          n.dp = 1'b1;
        end
        `SLOT_UNITS: begin
          n.glyph = digit(unit);
          n.dp = 1'b1;
        end
        default: n.glyph = G_BLANK;
      endcase
    end
    if (warning && r.flash) begin
      n.dp = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r <= '{st: ST_INIT, glyph: G_0, code: `CODE_INIT, default: '0};
    end else begin
      r <= n;
    end
  end

  assign sif.glyph = r.glyph;
  assign sif.dp = r.dp;

  seg_encoder u_enc (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .sif(sif.enc)
  );

  assign seg = sif.seg;
  assign seg_dp = sif.seg_dp;
  assign state_code = r.code;
  assign motor_power_en = r.motor_pwr;
  assign dc_monitor_on = r.dc_mon;
  assign fault_active = r.fault_any;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_fault_seen;
    det != `FAULT_NONE;
  endsequence

  sequence s_enter_qstop;
    r.st == ST_ENABLED && cmd_quick_stop && !cmd_disable &&
    det == `FAULT_NONE;
  endsequence

  sequence s_react_end;
    r.st == ST_REACT && err_reaction_done && det == `FAULT_NONE;
  endsequence

  a_power_cut_fault: assert property (
    s_fault_seen |=> !motor_power_en &&
    (state_code == `CODE_REACT || $past(r.st == ST_LOCKED)))
    else $error("motor power not cut on fault");
  a_phase_gated: assert property (
    phase_lost && three_phase_cfg |=> r.fault_pend[`F_PHASE])
    else $error("phase loss not latched");
  a_dc_over_limit: assert property (
    dc_link_volts > `DC_LINK_MAX_V |=> fault_active && !motor_power_en)
    else $error("dc link overvoltage missed");
  a_cable_first_enable: assert property (
    first_enable && cable_broken |=> r.fault_pend[`F_CABLE] && r.cable_tested)
    else $error("cable break not flagged");
  a_qstop_code: assert property (
    s_enter_qstop |=> state_code == `CODE_QSTOP ##1
    (state_code == `CODE_QSTOP || $past(speed_zero) || fault_active))
    else $error("quick stop code wrong");
  a_locked_after_react: assert property (
    s_react_end |=> state_code == `CODE_LOCKED && !motor_power_en)
    else $error("no state_fault_locked state after reaction");
  a_dc_monitor_on: assert property (
    state_code == `CODE_ON |-> dc_monitor_on)
    else $error("dc link monitor off while switched on");
  a_fault_letter: assert property (
    display_mode == `MODE_NORMAL && !boot_active && fault_active &&
    r.slot == `SLOT_LETTER |=> ##1 seg == 7'h71)
    else $error("fault letter not shown");
  a_ack_to_inhibit: assert property (
    r.st == ST_LOCKED && fault_ack && n.fault_pend == `FAULT_NONE
    |=> state_code == `CODE_INHIBIT)
    else $error("acknowledge did not reach inhibit");

endmodule // drive_state_fault_display

// *** sim/seg_reader.sv ***
`timescale 1ns/1ps
module seg_reader import drive_pkg::*; (
  seg,
  glyph_seen
);
  input wire logic [6:0] seg;
  output glyph_t glyph_seen;
  // operator view: segment pattern back to a character
  always_comb begin
    case (seg)
      7'h3f: glyph_seen = G_0;
      7'h06: glyph_seen = G_1;
      7'h5b: glyph_seen = G_2;
      7'h4f: glyph_seen = G_3;
      7'h66: glyph_seen = G_4;
      7'h07: glyph_seen = G_7;
      7'h39: glyph_seen = G_C;
      7'h79: glyph_seen = G_E;
      7'h71: glyph_seen = G_F;
      7'h38: glyph_seen = G_L;
      7'h73: glyph_seen = G_P;
      7'h3e: glyph_seen = G_U;
      default: glyph_seen = G_BLANK;
    endcase
  end
endmodule // seg_reader

// *** sim/drive_state_fault_display_tb.sv ***
`timescale 1ns/1ps
module drive_state_fault_display_tb;
  import drive_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic display_mode = 1'b0;
  logic init_done = 1'b0;
  logic cmd_arm = 1'b0;
  logic cmd_switch_on = 1'b0;
  logic cmd_enable = 1'b0;
  logic cmd_disable = 1'b0;
  logic cmd_quick_stop = 1'b0;
  logic speed_zero = 1'b0;
  logic err_reaction_done = 1'b0;
  logic fault_ack = 1'b0;
  logic three_phase_cfg = 1'b0;
  logic hw_defect = 1'b0;
  logic supply_bad = 1'b0;
  logic phase_lost = 1'b0;
  logic cable_broken = 1'b0;
  logic [9:0] dc_link_volts = 10'h0e6;
  logic boot_active = 1'b0;
  logic [2:0] boot_phase = 3'h0;
  logic warning = 1'b0;
  logic [6:0] seg;
  logic seg_dp;
  logic [3:0] state_code;
  logic motor_power_en;
  logic dc_monitor_on;
  logic fault_active;
  glyph_t seen;
  int failures = 0;
  int checked = 0;
  glyph_t boot_exp [6] = '{G_0, G_C, G_E, G_L, G_P, G_U};

  always #25 clk_sys = ~clk_sys;

  drive_state_fault_display #(.SEQ_CYCLES(40)) dut (.clk_sys, .resetn,
    .display_mode, .init_done, .cmd_arm, .cmd_switch_on, .cmd_enable,
    .cmd_disable, .cmd_quick_stop, .speed_zero, .err_reaction_done,
    .fault_ack, .three_phase_cfg, .hw_defect, .supply_bad, .phase_lost,
    .cable_broken, .dc_link_volts, .boot_active, .boot_phase, .warning,
    .seg, .seg_dp, .state_code, .motor_power_en, .dc_monitor_on,
    .fault_active);

  seg_reader rd (.seg(seg), .glyph_seen(seen));

  task final_report;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task code_is(input string what, input logic [3:0] exp);
    chk(what, {4'h0, exp}, {4'h0, state_code});
  endtask

  // bounded wait for a character, optionally with the dot lit
  task watch(input string what, input glyph_t g, input logic need_dp);
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < 100 && !hit; i++) begin
      @(negedge clk_sys);
      hit = (seen === g) && (!need_dp || seg_dp === 1'b1);
    end
    chk(what, 8'h01, {7'h00, hit});
    if (!hit)
      final_report;
  endtask

  task start_up;
    resetn = 1'b0;
    cyc(16);
    resetn = 1'b1;
    code_is("init", 4'h0);
    watch("init glyph", G_0, 1'b0);
    init_done = 1'b1;
    cyc(1);
    init_done = 1'b0;
    code_is("inhibit", 4'h1);
  endtask

  task to_on;
    cmd_arm = 1'b1;
    cyc(1);
    cmd_arm = 1'b0;
    code_is("armable", 4'h2);
    cmd_switch_on = 1'b1;
    cyc(1);
    cmd_switch_on = 1'b0;
    code_is("on", 4'h3);
    chk("dc mon", 8'h01, {7'h00, dc_monitor_on});
  endtask

  task enable;
    cmd_enable = 1'b1;
    cyc(1);
    cmd_enable = 1'b0;
  endtask

  task react_done;
    err_reaction_done = 1'b1;
    cyc(1);
    err_reaction_done = 1'b0;
    code_is("locked", 4'hf);
  endtask

  task ack;
    fault_ack = 1'b1;
    cyc(1);
    fault_ack = 1'b0;
  endtask

  task sc_power_up;
    start_up;
    to_on;
    enable;
    code_is("enabled", 4'h4);
    chk("power", 8'h01, {7'h00, motor_power_en});
    cmd_disable = 1'b1;
    cyc(1);
    cmd_disable = 1'b0;
    code_is("disabled", 4'h2);
    chk("disabled power", 8'h00, {7'h00, motor_power_en});
    chk("disabled dc mon", 8'h00, {7'h00, dc_monitor_on});
    cmd_switch_on = 1'b1;
    cyc(1);
    cmd_switch_on = 1'b0;
    code_is("on again", 4'h3);
    enable;
    code_is("enabled again", 4'h4);
  endtask

  task sc_quick_stop;
    cmd_quick_stop = 1'b1;
    cyc(1);
    cmd_quick_stop = 1'b0;
    code_is("qstop", 4'h7);
    speed_zero = 1'b1;
    cyc(1);
    speed_zero = 1'b0;
    code_is("qstop end", 4'h1);
  endtask

  task sc_modes;
    to_on;
    cable_broken = 1'b1;
    enable;
    cyc(2);
    code_is("second enable", 4'h4);
    cable_broken = 1'b0;
    display_mode = 1'b1;
    watch("mode 1", G_4, 1'b1);
    display_mode = 1'b0;
    cyc(3);
    chk("mode 0 dot", 8'h00, {7'h00, seg_dp});
    warning = 1'b1;
    watch("warn dot", G_4, 1'b1);
    warning = 1'b0;
  endtask

  task sc_dc_link;
    dc_link_volts = 10'h1e0;
    cyc(2);
    code_is("dc at limit", 4'h4);
    dc_link_volts = 10'h1e1;
    cyc(1);
    dc_link_volts = 10'h0e6;
    code_is("dc react", 4'he);
    chk("dc power", 8'h00, {7'h00, motor_power_en});
    chk("dc fault", 8'h01, {7'h00, fault_active});
    react_done;
    watch("letter", G_F, 1'b0);
    watch("tens", G_0, 1'b1);
    watch("units", G_4, 1'b1);
    ack;
    code_is("dc ack", 4'h1);
    chk("dc cleared", 8'h00, {7'h00, fault_active});
  endtask

  task sc_phase;
    phase_lost = 1'b1;
    cyc(3);
    chk("phase single", 8'h00, {7'h00, fault_active});
    three_phase_cfg = 1'b1;
    cyc(1);
    phase_lost = 1'b0;
    code_is("phase react", 4'he);
    react_done;
    watch("phase num", G_2, 1'b1);
    ack;
    code_is("phase ack", 4'h1);
    chk("phase cleared", 8'h00, {7'h00, fault_active});
  endtask

  task sc_boot;
    boot_active = 1'b1;
    for (int p = 0; p < 6; p++) begin
      boot_phase = p[2:0];
      watch("boot", boot_exp[p], 1'b1);
    end
    watch("boot blank", G_BLANK, 1'b0);
    boot_active = 1'b0;
  endtask

  task sc_cable_hw;
    start_up;
    to_on;
    cable_broken = 1'b1;
    enable;
    cyc(2);
    cable_broken = 1'b0;
    code_is("cable", 4'he);
    react_done;
    watch("cable num", G_3, 1'b1);
    ack;
    code_is("cable ack", 4'h1);
    to_on;
    enable;
    code_is("enabled no test", 4'h4);
    chk("power before hw", 8'h01, {7'h00, motor_power_en});
    hw_defect = 1'b1;
    cyc(1);
    hw_defect = 1'b0;
    chk("hw power", 8'h00, {7'h00, motor_power_en});
    code_is("hw react", 4'he);
    react_done;
    ack;
    code_is("hw kept", 4'hf);
    chk("hw fault", 8'h01, {7'h00, fault_active});
    watch("hw num", G_0, 1'b1);
  endtask

  task sc_supply;
    start_up;
    supply_bad = 1'b1;
    cyc(1);
    supply_bad = 1'b0;
    code_is("supply", 4'he);
    react_done;
    ack;
    code_is("supply kept", 4'hf);
    chk("supply fault", 8'h01, {7'h00, fault_active});
  endtask

  initial begin
    sc_power_up;
    sc_quick_stop;
    sc_modes;
    sc_dc_link;
    sc_phase;
    sc_boot;
    sc_cable_hw;
    sc_supply;
    final_report;
  end
endmodule // drive_state_fault_display_tb
